// ==== bench/bcse_engine_test.sv ====
// testbench: instruction programs run through the sequence engine
`default_nettype none
module bcse_engine_test;
  import bcse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic prdy;
  logic perr;
  logic ack;
  logic done;
  logic running;
  logic [15:0] rdata;
  logic [15:0] bsw;
  logic [15:0] ttv;
  logic ttl;
  logic [3:0] irq;
  logic [3:0] irq_seen = 4'h0;
  logic [15:0] mptr = 16'h0000;
  logic [31:0] rd;
  logic er;
  logic [15:0] q[$];
  bcse_mem_s mem;
  bcse_msg_s msg;
  bcse_gpq_s gpq;
  int msgs = 0;
  int tls = 0;
  int err_total = 0;
  int tests_run = 0;
  bcse_engine #(.FRAME_TICK_CYC(20)) uut (.I_CORE_CLK(clk), .I_RST(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(prdy),
    .O_PSLVERR(perr), .O_MEM(mem), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata),
    .O_MSG(msg), .I_MSG_DONE(done), .I_MSG_BSW(bsw), .I_MSG_FLAGS(7'h00),
    .O_GPQ(gpq), .O_SEQ_IRQ(irq), .O_TT_LOAD(ttl), .O_TT_VALUE(ttv),
    .I_TT_VALUE(ttv), .I_EXT_TRIG(1'b0), .O_RUNNING(running));
  bcse_partner m (.clk(clk), .i_mem(mem), .o_ack(ack), .o_rdata(rdata),
    .i_msg(msg), .o_done(done), .o_bsw(bsw));
  // record queue pushes, message starts and interrupt patterns
  always @(posedge clk)
  begin
    if (gpq.push === 1'b1)
      q.push_back(gpq.data);
    if (msg.start === 1'b1)
    begin
      msgs++;
      mptr = msg.ptr;
    end
    irq_seen = irq_seen | irq;
    if (ttl === 1'b1)
      tls++;
  end
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1 && ++n < 20);
    rd = prdata;
    er = perr;
    chk("pready", 32'h1, prdy);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic put(input logic [7:0] a, input logic [4:0] op,
    input logic [4:0] cc, input logic [15:0] par);
    logic [14:0] b;
    b = {op, OP_PATTERN, cc};
    m.ram[a] = {~^b, b};
    m.ram[a + 8'h01] = par;
  endtask : put
  // start at list address, wait for the engine to halt
  task automatic run(input logic [15:0] list);
    int n;
    n = 0;
    apb(1'b1, REG_LIST, {16'h0000, list});
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    while (running !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    while (running !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chk("halted", 32'h1, {31'h0, n < 4000});
  endtask : run
  task automatic test_flow();
    q.delete();
    msgs = 0;
    irq_seen = 4'h0;
    run(16'h0000);
    chk("queue size", 32'h4, q.size());
    chk("push imm", 32'h1234, q[0]);
    chk("push bsw", 32'h0123, q[1]);
    chk("sub push", 32'hBEEF, q[2]);
    chk("push mem", 32'h5A5A, q[3]);
    chk("msg count", 32'h1, msgs);
    chk("msg ptr", 32'h0040, mptr);
    chk("irq", 32'h5, irq_seen);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h01, rd[6:0]);
    $display("test flow done");
  endtask : test_flow
  task automatic test_flip();
    run(16'h0060);
    chk("flip ptr", 32'h0090, m.ram[8'h61]);
    chk("msg ptr", 32'h0080, mptr);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk("flags", 32'h06, rd[7:0]);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("parity", 32'h4, rd[3:0]);
    $display("test flip done");
  endtask : test_flip
  task automatic test_time();
    q.delete();
    run(16'h0040);
    chk("keep ptr", 32'h00A0, m.ram[8'h41]);
    chk("time queue", 32'h2, q.size());
    chk("lt push", 32'h0011, q[0]);
    chk("tt push", 32'h7777, q[1]);
    chk("tt loads", 32'h1, tls);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk("cmp flags", 32'h0, rd[1:0]);
    apb(1'b0, REG_TIMERS, 32'h0);
    chk("timers", 32'h0, rd);
    $display("test time done");
  endtask : test_time
  task automatic test_err();
    run(16'h0070);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("underflow", 32'h8, rd[3:0]);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    $display("test errors done");
  endtask : test_err
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // clock generator
  initial
    forever #4 clk = ~clk;
  // watchdog against a hung engine or bus
  initial
  begin
    #400000;
    err_total++;
    final_report();
  end
  // load programs, reset, run the tests
  initial
  begin
    put(8'h00, OP_PSI, 5'h0F, 16'h1234);
    put(8'h02, OP_XEQ, 5'h0F, 16'h0040);
    put(8'h04, OP_XEQ, 5'h1F, 16'h0050);
    put(8'h06, OP_PBS, 5'h0F, 16'h0000);
    put(8'h08, OP_IRQ, 5'h0F, 16'h0005);
    put(8'h0A, OP_JMP, 5'h0F, 16'h0010);
    put(8'h0C, OP_PSI, 5'h0F, 16'hDEAD);
    put(8'h10, OP_CAL, 5'h0F, 16'h0020);
    put(8'h12, OP_PSM, 5'h0F, 16'h0030);
    put(8'h14, OP_HLT, 5'h0F, 16'h0000);
    put(8'h20, OP_PSI, 5'h0F, 16'hBEEF);
    put(8'h22, OP_RTN, 5'h0F, 16'h0000);
    m.ram[8'h30] = 16'h5A5A;
    put(8'h60, OP_XQF, 5'h0F, 16'h0080);
    put(8'h62, OP_FLG, 5'h0F, 16'h0104);
    put(8'h64, OP_CMT, 5'h0F, 16'h0000);
    put(8'h66, OP_PSI, 5'h0F, 16'h0000);
    m.ram[8'h66] = m.ram[8'h66] ^ 16'h8000;
    put(8'h70, OP_RTN, 5'h0F, 16'h0000);
    put(8'h40, OP_XQF, 5'h1F, 16'h00A0);
    put(8'h42, OP_LFT, 5'h0F, 16'h0003);
    put(8'h44, OP_SFT, 5'h0F, 16'h0000);
    put(8'h46, OP_CFT, 5'h0F, 16'h0001);
    put(8'h48, OP_PSI, 5'h00, 16'h0011);
    put(8'h4A, OP_WFT, 5'h0F, 16'h0000);
    put(8'h4C, OP_CFT, 5'h0F, 16'h0002);
    put(8'h4E, OP_DLY, 5'h0F, 16'h0002);
    put(8'h50, OP_LTT, 5'h0F, 16'h7777);
    put(8'h52, OP_PTT, 5'h0F, 16'h0000);
    put(8'h54, OP_HLT, 5'h0F, 16'h0000);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_LIST, 32'h0);
    chk("list reset", {16'h0000, LIST_RST}, rd);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk("flags reset", {24'h000000, FLAGS_RST}, rd);
    test_flow();
    test_flip();
    test_time();
    test_err();
    final_report();
  end
endmodule : bcse_engine_test
`default_nettype wire

// ==== bench/bcse_partner.sv ====
// partner model: shared ram and message responder
`default_nettype none
module bcse_partner
  import bcse_pkg::*;
(
  input wire logic clk,
  input wire bcse_mem_s i_mem,
  output logic o_ack = 1'b0,
  output logic [15:0] o_rdata = 16'h0000,
  input wire bcse_msg_s i_msg,
  output logic o_done = 1'b0,
  output logic [15:0] o_bsw = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ram [0:255];
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  // ram acks one wait cycle after a request, data only with ack
  always @(posedge clk)
  begin
    pend <= i_mem.req && !o_ack && !pend;
    o_ack <= i_mem.req && !o_ack && pend;
    o_rdata <= pend ? ram[i_mem.addr[7:0]] : ~o_rdata;
    if (o_ack && i_mem.req && i_mem.we)
      ram[i_mem.addr[7:0]] <= i_mem.wdata;
  end
  // message ends six cycles after start, status word valid with done
  always @(posedge clk)
  begin
    cnt <= i_msg.start ? 4'h6 : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
    o_done <= cnt == 4'h1;
    o_bsw <= cnt == 4'h1 ? 16'hC123 : ~o_bsw;
  end
endmodule : bcse_partner
`default_nettype wire

// ==== hdl/bcse_engine.sv ====
// sequence engine: fetch, decode and execute of the message program
// Notes on behaviour
// [RL1] flip op: run message, then flip bit 4
// [RL2] execute op runs message on true condition
// [RL3] jump op branches to parameter when true
// [RL4] call pushes next address, four deep maximum
// [RL5] return resumes at popped address when true
// [RL6] interrupt op sets four sequencer bits
// [RL7] halt stops until host start command
// [RL8] delay counts parameter microseconds before fetch
// [RL9] frame wait holds until frame counter zero
// [RL10] frame compare sets less and equal flags
// [RL11] message compare uses the message timer
// [RL12] message compare zero means equal flags
// [RL13] flag op: two bits per flag action
// [RL14] time tag load from parameter when true
// [RL15] frame timer register load when true
// [RL16] frame counter starts from timer register
// [RL17] push time tag onto queue
// [RL18] push block status, top two bits cleared
// [RL19] push parameter as immediate word
// [RL20] push word read from parameter address
// [RL21] bad code, parity or pattern halts
// [RL22] condition: four-bit select, bit 4 inverts
// [RL23] stack overflow or underflow halts engine
// [RL24] false flip condition leaves pointer unchanged
//
// Our own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module bcse_engine #(
  parameter int FRAME_TICK_CYC = bcse_pkg::TICK_100US_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output bcse_pkg::bcse_mem_s O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [15:0] I_MEM_RDATA,
  output bcse_pkg::bcse_msg_s O_MSG,
  input wire logic I_MSG_DONE,
  input wire logic [15:0] I_MSG_BSW,
  input wire logic [6:0] I_MSG_FLAGS,
  output bcse_pkg::bcse_gpq_s O_GPQ,
  output logic [3:0] O_SEQ_IRQ,
  output logic O_TT_LOAD,
  output logic [15:0] O_TT_VALUE,
  input wire logic [15:0] I_TT_VALUE,
  input wire logic I_EXT_TRIG,
  output logic O_RUNNING
);
  import bcse_pkg::*;

  // ****************************************************************
  // state and decode
  // ****************************************************************
  bcse_state_e state_r;
  logic [15:0] pc_r, op_r, par_r, list_r, last_bsw_r;
  logic [15:0] msg_tmr_r, frame_cnt_r, frame_reg_r, frame_pre_r;
  logic [6:0] us_pre_r;
  logic [7:0] gp_r;
  logic [3:0] halt_r;
  logic [2:0] depth_r;
  logic [15:0] stack_r [0:3];
  bcse_mem_s mem_r;
  bcse_msg_s msg_r;
  bcse_gpq_s gpq_r;
  logic [3:0] irq_r;
  logic tt_load_r, run_r, pready_r, pslverr_r;
  logic [15:0] tt_val_r;
  logic [31:0] prdata_r;
  logic trig_s1_r, trig_s2_r, trig_d_r;
  logic [4:0] opc, ex_is;
  logic [15:0] all_flags, pc_next, cmp_val;
  logic cond, legal, uncond, ex, stk_err, tick_us, tick_fr, mem_ok;
  logic host_start, host_stop, apb_fire, apb_wr;

  assign opc = op_r[14:10];
  // condition code: select one of sixteen flags, bit 4 inverts
  assign all_flags = {1'b1, I_MSG_FLAGS, gp_r};
  assign cond = all_flags[op_r[3:0]] ^ op_r[4]; // [RL22]
  // odd parity, fixed pattern and defined code
  assign legal = (^op_r) && (op_r[9:5] == OP_PATTERN) &&
                 (opc != 5'h00) && (opc != OP_GAP) &&
                 (opc <= OP_LAST); // [RL21]
  assign uncond = (opc == OP_XQF) || (opc == OP_CFT) ||
                  (opc == OP_CMT) || (opc == OP_FLG);
  assign ex = (state_r == ST_DECODE) && legal && (cond || uncond);
  assign ex_is = ex ? opc : 5'h00;
  assign stk_err = ((ex_is == OP_CAL) && (depth_r == STACK_DEPTH)) ||
                   ((ex_is == OP_RTN) && (depth_r == 3'h0)); // [RL23]
  assign pc_next = 16'(pc_r + PC_STEP);
  assign mem_ok = mem_r.req && I_MEM_ACK;
  assign cmp_val = (opc == OP_CMT) ? msg_tmr_r : frame_cnt_r; // [RL11]
  assign apb_fire = I_PSEL && I_PENABLE && pready_r;
  assign apb_wr = apb_fire && I_PWRITE && (I_PADDR == REG_CTRL);
  assign host_start = apb_wr && I_PWDATA[CTRL_START_BIT];
  assign host_stop = apb_wr && I_PWDATA[CTRL_STOP_BIT];

  // ****************************************************************
  // sequencer state machine
  // ****************************************************************
  // fetch op and parameter, dispatch, wait states
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_r <= ST_IDLE;
      pc_r <= 16'h0000;
      op_r <= 16'h0000;
      par_r <= 16'h0000;
      mem_r <= '0;
      msg_r <= '0;
      halt_r <= 4'h0;
    end
    else
    begin
      msg_r.start <= 1'b0;
      if (host_stop)
      begin
        state_r <= ST_IDLE;
        mem_r.req <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            // only a host start leaves idle
            if (host_start) // [RL7]
            begin
              pc_r <= list_r;
              halt_r <= 4'h0;
              state_r <= ST_FETCH_OP;
            end
          end
          ST_FETCH_OP, ST_FETCH_PAR:
          begin
            if (mem_ok)
            begin
              mem_r.req <= 1'b0;
              if (state_r == ST_FETCH_OP)
              begin
                op_r <= I_MEM_RDATA;
                state_r <= ST_FETCH_PAR;
              end
              else
              begin
                par_r <= I_MEM_RDATA;
                state_r <= ST_DECODE;
              end
            end
            else if (!mem_r.req)
            begin
              mem_r.req <= 1'b1;
              mem_r.we <= 1'b0;
              mem_r.addr <= (state_r == ST_FETCH_OP) ? pc_r : 16'(pc_r + 1);
            end
          end
          ST_DECODE:
          begin
            if (!legal)
            begin
              state_r <= ST_IDLE; // [RL21]
              halt_r[2] <= ~(^op_r);
              halt_r[1] <= ^op_r;
            end
            else if (stk_err)
            begin
              state_r <= ST_IDLE; // [RL23]
              halt_r[3] <= 1'b1;
            end
            else if (!ex)
            begin
              pc_r <= pc_next;
              state_r <= ST_FETCH_OP;
            end
            else
            begin
              case (opc)
                OP_XEQ, OP_XQF:
                begin
                  msg_r.start <= 1'b1; // [RL2] [RL1]
                  msg_r.ptr <= par_r;
                  state_r <= ST_MSG;
                end
                OP_JMP, OP_CAL:
                begin
                  pc_r <= par_r; // [RL3] [RL4]
                  state_r <= ST_FETCH_OP;
                end
                OP_RTN:
                begin
                  pc_r <= stack_r[2'(depth_r - 3'h1)]; // [RL5]
                  state_r <= ST_FETCH_OP;
                end
                OP_HLT:
                begin
                  halt_r[0] <= 1'b1; // [RL7]
                  state_r <= ST_IDLE;
                end
                OP_DLY: state_r <= ST_WAIT_MT; // [RL8]
                OP_WFT: state_r <= ST_WAIT_FT; // [RL9]
                OP_WTG: state_r <= ST_WAIT_TRIG;
                OP_PSM: state_r <= ST_IND; // [RL20]
                default:
                begin
                  pc_r <= pc_next;
                  state_r <= ST_FETCH_OP;
                end
              endcase
            end
          end
          ST_MSG:
            if (I_MSG_DONE)
              state_r <= (opc == OP_XQF) ? ST_POST : ST_FETCH_OP;
          ST_POST:
          begin
            // flip only on a true condition after the message
            if (cond) // [RL1] [RL24]
              state_r <= ST_FLIP;
            else
              state_r <= ST_FETCH_OP;
          end
          ST_FLIP:
          begin
            if (mem_ok)
            begin
              mem_r.req <= 1'b0;
              state_r <= ST_FETCH_OP;
            end
            else if (!mem_r.req)
            begin
              mem_r <= '{1'b1, 1'b1, 16'(pc_r + 1), par_r ^ FLIP_MASK}; // [RL1]
            end
          end
          ST_IND:
          begin
            if (mem_ok)
            begin
              mem_r.req <= 1'b0;
              state_r <= ST_FETCH_OP;
            end
            else if (!mem_r.req)
            begin
              mem_r.req <= 1'b1; // [RL20]
              mem_r.we <= 1'b0;
              mem_r.addr <= par_r;
            end
          end
          ST_WAIT_MT:
            if (msg_tmr_r == 16'h0000)
              state_r <= ST_FETCH_OP; // [RL8]
          ST_WAIT_FT:
            if (frame_cnt_r == 16'h0000)
              state_r <= ST_FETCH_OP; // [RL9]
          ST_WAIT_TRIG:
            if (trig_s2_r && !trig_d_r)
              state_r <= ST_FETCH_OP;
          default: state_r <= ST_IDLE;
        endcase
        // leaving a multi-cycle op or wait moves past the parameter
        if ((state_r == ST_MSG && I_MSG_DONE && opc != OP_XQF) ||
            (state_r == ST_POST && !cond) || (state_r != ST_DECODE &&
            state_r != ST_FETCH_OP && state_r != ST_FETCH_PAR &&
            state_r != ST_IDLE && state_r != ST_MSG && state_r != ST_POST &&
            state_r != ST_WAIT_MT && state_r != ST_WAIT_FT &&
            state_r != ST_WAIT_TRIG && mem_ok) ||
            (state_r == ST_WAIT_MT && msg_tmr_r == 16'h0000) ||
            (state_r == ST_WAIT_FT && frame_cnt_r == 16'h0000) ||
            (state_r == ST_WAIT_TRIG && trig_s2_r && !trig_d_r))
          pc_r <= pc_next;
      end
    end
  end

  // ****************************************************************
  // call stack
  // ****************************************************************
  // push return address on call, pop on return
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      depth_r <= 3'h0;
    else if (state_r == ST_IDLE && host_start)
      depth_r <= 3'h0;
    else if (ex_is == OP_CAL && !stk_err)
    begin
      stack_r[depth_r[1:0]] <= pc_next; // [RL4]
      depth_r <= 3'(depth_r + 3'h1);
    end
    else if (ex_is == OP_RTN && !stk_err)
      depth_r <= 3'(depth_r - 3'h1); // [RL5]
  end

  // ****************************************************************
  // condition flags
  // ****************************************************************
  // engine op first, a host write in the same cycle is dropped
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      gp_r <= FLAGS_RST;
    else if (ex_is == OP_FLG)
      gp_r <= (gp_r & ~par_r[15:8] & ~par_r[7:0]) |
              (par_r[7:0] & ~par_r[15:8]) |
              (~gp_r & par_r[15:8] & par_r[7:0]); // [RL13]
    else if (ex_is == OP_CFT || ex_is == OP_CMT)
    begin
      gp_r[0] <= par_r < cmp_val; // [RL10] [RL12]
      gp_r[1] <= par_r == cmp_val;
    end
    else if (apb_fire && I_PWRITE && I_PADDR == REG_FLAGS)
      gp_r <= (gp_r & ~I_PWDATA[15:8] & ~I_PWDATA[7:0]) |
              (I_PWDATA[7:0] & ~I_PWDATA[15:8]) |
              (~gp_r & I_PWDATA[15:8] & I_PWDATA[7:0]);
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  assign tick_us = us_pre_r == 7'(TICK_1US_CYC - 1);
  assign tick_fr = frame_pre_r == 16'(FRAME_TICK_CYC - 1);
  // timebases, message timer and frame counter; frame freezes in idle
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      us_pre_r <= 7'h00;
      frame_pre_r <= 16'h0000;
      msg_tmr_r <= 16'h0000;
      frame_cnt_r <= 16'h0000;
      frame_reg_r <= 16'h0000;
    end
    else
    begin
      us_pre_r <= tick_us ? 7'h00 : 7'(us_pre_r + 7'h01);
      frame_pre_r <= tick_fr ? 16'h0000 : 16'(frame_pre_r + 16'h0001);
      if (ex_is == OP_DLY)
        msg_tmr_r <= par_r; // [RL8]
      else if (tick_us && msg_tmr_r != 16'h0000)
        msg_tmr_r <= 16'(msg_tmr_r - 16'h0001);
      if (ex_is == OP_LFT)
        frame_reg_r <= par_r; // [RL15]
      if (ex_is == OP_SFT)
        frame_cnt_r <= frame_reg_r; // [RL16]
      else if (tick_fr && state_r != ST_IDLE && frame_cnt_r != 16'h0000)
        frame_cnt_r <= 16'(frame_cnt_r - 16'h0001);
    end
  end

  // ****************************************************************
  // queue, interrupt, time tag and trigger
  // ****************************************************************
  // one-cycle strobes toward queue, interrupt and time tag logic
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      gpq_r <= '0;
      irq_r <= 4'h0;
      tt_load_r <= 1'b0;
      tt_val_r <= 16'h0000;
      last_bsw_r <= 16'h0000;
      run_r <= 1'b0;
    end
    else
    begin
      gpq_r.push <= 1'b1;
      irq_r <= (ex_is == OP_IRQ) ? par_r[3:0] : 4'h0; // [RL6]
      tt_load_r <= ex_is == OP_LTT; // [RL14]
      run_r <= state_r != ST_IDLE;
      if (ex_is == OP_LTT)
        tt_val_r <= par_r;
      if (state_r == ST_MSG && I_MSG_DONE)
        last_bsw_r <= I_MSG_BSW;
      case (ex_is)
        OP_PTT: gpq_r.data <= I_TT_VALUE; // [RL17]
        OP_PBS: gpq_r.data <= last_bsw_r & BSW_KEEP; // [RL18]
        OP_PSI: gpq_r.data <= par_r; // [RL19]
        default:
        begin
          gpq_r.data <= I_MEM_RDATA; // [RL20]
          gpq_r.push <= state_r == ST_IND && mem_ok;
        end
      endcase
    end
  end

  // external trigger pin: two stages, then edge history
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end
    else
    begin
      trig_s1_r <= I_EXT_TRIG;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // answer in the second access cycle, unmapped reads zero with error
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      list_r <= LIST_RST;
    end
    else
    begin
      pready_r <= I_PSEL && I_PENABLE && !pready_r;
      if (apb_fire && I_PWRITE && I_PADDR == REG_LIST)
        list_r <= I_PWDATA[15:0];
      if (I_PSEL && I_PENABLE && !pready_r)
      begin
        pslverr_r <= 1'b0;
        case (I_PADDR)
          REG_CTRL: prdata_r <= 32'h0000_0000;
          REG_STATUS: prdata_r <= {pc_r, 8'h00, 1'b0, depth_r, halt_r};
          REG_FLAGS: prdata_r <= {24'h00_0000, gp_r};
          REG_LIST: prdata_r <= {16'h0000, list_r};
          REG_TIMERS: prdata_r <= {msg_tmr_r, frame_cnt_r};
          REG_FRAME: prdata_r <= {16'h0000, frame_reg_r};
          default:
          begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b1;
          end
        endcase
      end
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_MEM = mem_r;
  assign O_MSG = msg_r;
  assign O_GPQ = gpq_r;
  assign O_SEQ_IRQ = irq_r;
  assign O_TT_LOAD = tt_load_r;
  assign O_TT_VALUE = tt_val_r;
  assign O_RUNNING = run_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sequence s_bad_decode;
    state_r == ST_DECODE && !legal;
  endsequence
  sequence s_stay_idle;
    (state_r == ST_IDLE && (!host_start || host_stop)) ##1
    state_r == ST_IDLE;
  endsequence
  a_flip_data: assert property (state_r == ST_FLIP && mem_r.req |->
    mem_r.we && mem_r.wdata == (par_r ^ 16'h0010)) // [RL1]
    else $error("flip write data wrong");
  a_flip_skip: assert property (state_r == ST_POST && !cond && !host_stop |=>
    state_r == ST_FETCH_OP ##1 !mem_r.we) // [RL24]
    else $error("pointer flipped on false condition");
  a_jump_pc: assert property (ex_is == OP_JMP |=>
    pc_r == $past(par_r) && state_r == ST_FETCH_OP) // [RL3]
    else $error("jump target wrong");
  a_call_push: assert property (ex_is == OP_CAL && !stk_err |=>
    depth_r == $past(depth_r) + 3'h1) // [RL4]
    else $error("call did not push");
  a_stack_halt: assert property (stk_err |=> state_r == ST_IDLE &&
    halt_r[3]) // [RL23]
    else $error("stack error did not halt");
  a_irq_bits: assert property (ex_is == OP_IRQ |=>
    O_SEQ_IRQ == $past(par_r[3:0]) ##1 O_SEQ_IRQ == 4'h0) // [RL6]
    else $error("sequencer interrupt bits wrong");
  a_halt_hold: assert property (ex_is == OP_HLT |=> s_stay_idle or
    (state_r == ST_IDLE && host_start && !host_stop ##1
    state_r == ST_FETCH_OP)) // [RL7]
    else $error("halt did not stop program");
  a_bad_halt: assert property (s_bad_decode |=> state_r == ST_IDLE &&
    halt_r[2:1] != 2'h0) // [RL21]
    else $error("illegal op word not halted");
  a_delay_wait: assert property (state_r == ST_WAIT_MT && !host_stop &&
    msg_tmr_r != 16'h0000 |=> state_r == ST_WAIT_MT) // [RL8]
    else $error("delay ended early");
  a_bsw_push: assert property (ex_is == OP_PBS |=> O_GPQ.push &&
    O_GPQ.data[15:14] == 2'h0) // [RL18]
    else $error("block status push wrong");
endmodule : bcse_engine
`default_nettype wire

// ==== include/bcse_pkg.sv ====
// package: constants, carriers and states of the sequence engine
`default_nettype none
package bcse_pkg;
  // ****************************************************************
  // op codes (bits 14-10 of the op code word)
  // ****************************************************************
  localparam logic [4:0] OP_XEQ = 5'h01;
  localparam logic [4:0] OP_JMP = 5'h02;
  localparam logic [4:0] OP_CAL = 5'h03;
  localparam logic [4:0] OP_RTN = 5'h04;
  localparam logic [4:0] OP_IRQ = 5'h06;
  localparam logic [4:0] OP_HLT = 5'h07;
  localparam logic [4:0] OP_DLY = 5'h08;
  localparam logic [4:0] OP_WFT = 5'h09;
  localparam logic [4:0] OP_CFT = 5'h0A;
  localparam logic [4:0] OP_CMT = 5'h0B;
  localparam logic [4:0] OP_FLG = 5'h0C;
  localparam logic [4:0] OP_LTT = 5'h0D;
  localparam logic [4:0] OP_LFT = 5'h0E;
  localparam logic [4:0] OP_SFT = 5'h0F;
  localparam logic [4:0] OP_PTT = 5'h10;
  localparam logic [4:0] OP_PBS = 5'h11;
  localparam logic [4:0] OP_PSI = 5'h12;
  localparam logic [4:0] OP_PSM = 5'h13;
  localparam logic [4:0] OP_WTG = 5'h14;
  localparam logic [4:0] OP_XQF = 5'h15;
  localparam logic [4:0] OP_GAP = 5'h05;
  localparam logic [4:0] OP_LAST = 5'h15;
  // ****************************************************************
  // op word fields and masks
  // ****************************************************************
  localparam logic [4:0] OP_PATTERN = 5'h0A;
  localparam logic [15:0] FLIP_MASK = 16'h0010;
  localparam logic [15:0] BSW_KEEP = 16'h3FFF;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [2:0] STACK_DEPTH = 3'h4;
  // ****************************************************************
  // register offsets, fields and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_LIST = 8'h0C;
  localparam logic [7:0] REG_TIMERS = 8'h10;
  localparam logic [7:0] REG_FRAME = 8'h14;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam logic [15:0] LIST_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int FRAME_LSB_US = 100;
  localparam int TICK_1US_CYC = US_NS / CLK_PERIOD_NS;
  localparam int TICK_100US_CYC = FRAME_LSB_US * TICK_1US_CYC;
  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bcse_mem_s;
  typedef struct packed {
    logic start;
    logic [15:0] ptr;
  } bcse_msg_s;
  typedef struct packed {
    logic push;
    logic [15:0] data;
  } bcse_gpq_s;
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_FETCH_OP = 11'h002,
    ST_FETCH_PAR = 11'h004,
    ST_DECODE = 11'h008,
    ST_MSG = 11'h010,
    ST_POST = 11'h020,
    ST_FLIP = 11'h040,
    ST_IND = 11'h080,
    ST_WAIT_MT = 11'h100,
    ST_WAIT_FT = 11'h200,
    ST_WAIT_TRIG = 11'h400
  } bcse_state_e;
endpackage : bcse_pkg
`default_nettype wire
